// [dv/mmc_regs_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module mmc_regs_monitor (
  input wire logic                   mclk,
  input wire logic                   srst,
  input wire mmc_ctrl_pkg::op_mode_t opMode,
  input wire logic                   registerSpaceSwitch,
  input wire logic [1:0]             eepromSizeSwitch,
  input wire logic [2:0]             ramSizeSwitch,
  input wire logic [15:0]            registerBlockBase,
  input wire logic [15:0]            regAddr,
  input wire logic [7:0]             regWdata,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [7:0]             regRdata,
  input wire logic [15:0]            cpuAddr,
  input wire logic                   eepromSelect,
  input wire logic                   romSelect,
  input wire logic [1:0]             stretchCycles
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire [15:0] ofs = regAddr - registerBlockBase;
  sequence misc_wr_s;
    regWrite && ofs == 16'h0013 && opMode == mmc_ctrl_pkg::MODE_SPECIAL_EXP;
  endsequence
  sequence held_s;
    opMode == mmc_ctrl_pkg::MODE_SPECIAL_EXP;
  endsequence
  chk_stretch_delay: assert property (misc_wr_s ##1 held_s |=> stretchCycles == $past(regWdata[3:2], 2))
    else $error("stretch not taken from write");
  chk_stretch_quiet: assert property (opMode inside {mmc_ctrl_pkg::MODE_PERIPHERAL, mmc_ctrl_pkg::MODE_SINGLE_CHIP} |=> stretchCycles == 2'h0)
    else $error("stretch active in single chip or peripheral");
  chk_rom_below: assert property (cpuAddr < 16'h4000 |=> !romSelect)
    else $error("rom selected below its area");
  chk_ee_none: assert property (eepromSizeSwitch == 2'h0 |=> !eepromSelect)
    else $error("eeprom selected with no space");
  chk_unmapped_zero: assert property (regRead && ofs == 16'h0015 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_misc_upper: assert property (regRead && ofs == 16'h0013 |=> regRdata[7:4] == 4'h0)
    else $error("misc upper bits not zero");
  chk_test_read: assert property (regRead && (ofs == 16'h0014 || ofs == 16'h0017) |=> regRdata == 8'h00)
    else $error("test register read wrong");
  chk_size_view: assert property (regRead && ofs == 16'h001C |=> regRdata == {$past(registerSpaceSwitch), 1'b0, $past(eepromSizeSwitch), 1'b0, $past(ramSizeSwitch)})
    else $error("size view wrong");
endmodule : mmc_regs_monitor
bind memory_map_control_regs mmc_regs_monitor i_mon (.mclk, .srst, .opMode, .registerSpaceSwitch,
  .eepromSizeSwitch, .ramSizeSwitch, .registerBlockBase, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .cpuAddr, .eepromSelect, .romSelect, .stretchCycles);
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                   mclk, srst, romResetEnable, registerSpaceSwitch, regWrite, regRead, rdPend;
  mmc_ctrl_pkg::op_mode_t opMode;
  logic [1:0]             eepromSizeSwitch;
  logic [2:0]             ramSizeSwitch;
  logic [15:0]            registerBlockBase, regAddr, cpuAddr, eeBase;
  logic [7:0]             regWdata, regRdata, expQ[$];
  logic                   eepromSelect, romSelect;
  logic [1:0]             stretchCycles;
  logic [15:0]            ramResetBase;
  logic [4:0]             eb;
  int                     failures, cmpCount, cycles, seed;
  localparam logic [15:0] RAM_TAB [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000,
                                          16'h1800, 16'h1000, 16'h0800, 16'h0000};
  memory_map_control_regs i_dut (.mclk, .srst, .opMode, .romResetEnable, .registerSpaceSwitch,
    .eepromSizeSwitch, .ramSizeSwitch, .registerBlockBase, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .cpuAddr, .eepromSelect, .romSelect, .stretchCycles, .ramResetBase);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmpCount++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic op(input logic w, input logic r, input logic [15:0] o, input logic [7:0] d);
    regWrite <= w;
    regRead  <= r;
    regAddr  <= registerBlockBase + o;
    regWdata <= d;
    @(posedge mclk);
  endtask : op
  // the answer is judged at the falling edge, away from the edge that clears it
  task automatic rd(input logic [15:0] o, input logic [7:0] e);
    expQ.push_back(e);
    op(1'b0, 1'b1, o, 8'h00);
  endtask : rd
  task automatic look(input int n);
    repeat (n) op(1'b0, 1'b0, 16'h0000, 8'h00);
    #1;
  endtask : look
  always @(posedge mclk) rdPend <= (regRead === 1'b1);
  always @(negedge mclk) if (rdPend === 1'b1) chk("read data", expQ.pop_front(), regRdata);
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    seed = 32'h857B;
    {srst, regWrite, regRead, regAddr, regWdata, cpuAddr, ramSizeSwitch} = {1'b1, 45'h0};
    opMode = mmc_ctrl_pkg::MODE_NORMAL_EXP;
    registerBlockBase = 16'h0800;
    {romResetEnable, registerSpaceSwitch} = 2'($random(seed));
    eepromSizeSwitch = 2'($random(seed)) | 2'h1;
    eb = 5'($random(seed));
    eeBase = {eb, 11'h000};
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    look(2);
    rd(16'h0013, {6'h03, 1'b0, romResetEnable});
    op(1'b1, 1'b0, 16'h0014, 8'hA5);
    op(1'b1, 1'b0, 16'h0017, 8'h5A);
    op(1'b1, 1'b0, 16'h001C, 8'hFF);
    rd(16'h0014, 8'h00);
    rd(16'h0017, 8'h00);
    rd(16'h001C, {registerSpaceSwitch, 1'b0, eepromSizeSwitch, 1'b0, 3'h0});
    rd(16'h0015, 8'h00);
    // second write in a normal mode must bounce off the lock
    op(1'b1, 1'b0, 16'h0013, 8'h09);
    op(1'b1, 1'b0, 16'h0013, 8'h02);
    look(2);
    chk("locked stretch", 16'h0002, stretchCycles);
    rd(16'h0013, 8'h09);
    op(1'b1, 1'b0, 16'h0012, {~eb, 3'h1});
    op(1'b1, 1'b0, 16'h0012, {eb, 3'h1});
    cpuAddr <= eeBase + 16'h0010;
    look(2);
    chk("eeprom inside", 16'h0001, eepromSelect);
    cpuAddr <= eeBase + (16'h0400 << eepromSizeSwitch);
    look(2);
    chk("eeprom past end", 16'h0000, eepromSelect);
    cpuAddr <= eeBase;
    op(1'b1, 1'b0, 16'h0012, {eb, 3'h0});
    look(2);
    chk("eeprom off", 16'h0000, eepromSelect);
    op(1'b1, 1'b0, 16'h0012, {eb, 3'h1});
    look(2);
    chk("eeprom back on", 16'h0001, eepromSelect);
    opMode <= mmc_ctrl_pkg::MODE_SINGLE_CHIP;
    look(2);
    chk("single chip stretch", 16'h0000, stretchCycles);
    opMode <= mmc_ctrl_pkg::MODE_SPECIAL_EXP;
    for (int i = 0; i < 16; i++) begin
      cpuAddr <= 16'h4000;
      op(1'b1, 1'b0, 16'h0013, {4'($random(seed)), 4'(i)});
      look(2);
      chk("stretch", 16'(i[3:2]), stretchCycles);
      chk("rom low half", 16'(i[0] & ~i[1]), romSelect);
      cpuAddr <= 16'hC000;
      rd(16'h0013, 8'(i));
      look(1);
      chk("rom high half", 16'(i[0]), romSelect);
    end
    for (int i = 0; i < 8; i++) begin
      {registerSpaceSwitch, eepromSizeSwitch, ramSizeSwitch} <= {1'(i), 2'(i), 3'(i)};
      look(2);
      chk("ram base", RAM_TAB[i], ramResetBase);
      rd(16'h001C, {1'(i), 1'b0, 2'(i), 1'b0, 3'(i)});
    end
    registerBlockBase <= 16'h3800;
    look(1);
    rd(16'h0012, {eb, 3'h1});
    look(2);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// [include/mmc_ctrl_pkg.sv]
package mmc_ctrl_pkg;

  // register offsets within the relocatable register block
  localparam logic [10:0] OFS_EEPROM_POSITION = 11'h012;
  localparam logic [10:0] OFS_MISC_CONTROL    = 11'h013;
  localparam logic [10:0] OFS_TEST_A          = 11'h014;
  localparam logic [10:0] OFS_TEST_B          = 11'h017;
  localparam logic [10:0] OFS_SIZE_VIEW_A     = 11'h01C;

  // eeprom_position fields
  localparam int EE_BASE_MSB  = 7;
  localparam int EE_BASE_LSB  = 3;
  localparam int EE_ENABLE    = 0;
  localparam logic [7:0] EE_POSITION_RESET = 8'h01;

  // misc_system_control fields
  localparam int MISC_STRETCH_MSB = 3;
  localparam int MISC_STRETCH_LSB = 2;
  localparam int MISC_HIGH_HALF   = 1;
  localparam int MISC_ROM_ENABLE  = 0;
  localparam logic [1:0] STRETCH_RESET   = 2'h3;
  localparam logic       HIGH_HALF_RESET = 1'b0;

  // ram_position reset value, not used for the reset base of the ram array
  localparam logic [7:0] RAM_POSITION_RESET = 8'h09;

  // ram size code giving a full 16K region
  localparam logic [2:0] RAM_CODE_MAX = 3'h7;

  // ram reset base for each ram size code, high-aligned within its region
  localparam logic [15:0] RAM_BASE_CODE0 = 16'h0800;
  localparam logic [15:0] RAM_BASE_CODE1 = 16'h0000;
  localparam logic [15:0] RAM_BASE_CODE2 = 16'h0800;
  localparam logic [15:0] RAM_BASE_CODE3 = 16'h0000;
  localparam logic [15:0] RAM_BASE_CODE4 = 16'h1800;
  localparam logic [15:0] RAM_BASE_CODE5 = 16'h1000;
  localparam logic [15:0] RAM_BASE_CODE6 = 16'h0800;
  localparam logic [15:0] RAM_BASE_CODE7 = 16'h0000;

  // operating modes as seen by this block
  typedef enum logic [2:0] {
    MODE_NORMAL_EXP  = 3'h0,
    MODE_EMULATION   = 3'h1,
    MODE_PERIPHERAL  = 3'h2,
    MODE_SINGLE_CHIP = 3'h3,
    MODE_SPECIAL_SC  = 3'h4,
    MODE_SPECIAL_TST = 3'h5,
    MODE_SPECIAL_EXP = 3'h6
  } op_mode_t;

endpackage : mmc_ctrl_pkg

// [src/memory_map_control_regs.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module memory_map_control_regs #(
  parameter bit         EE_BASE_WRITE_ONCE = 1'b0,
  parameter logic [7:0] TEST_A_VALUE       = 8'h00,
  parameter logic [7:0] TEST_B_VALUE       = 8'h00
) (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire mmc_ctrl_pkg::op_mode_t    opMode,
  input  wire logic                      romResetEnable,
  input  wire logic                      registerSpaceSwitch,
  input  wire logic [1:0]                eepromSizeSwitch,
  input  wire logic [2:0]                ramSizeSwitch,
  input  wire logic [15:0]               registerBlockBase,
  input  wire logic [15:0]               regAddr,
  input  wire logic [7:0]                regWdata,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic [7:0]                     regRdata,
  input  wire logic [15:0]               cpuAddr,
  output logic                           eepromSelect,
  output logic                           romSelect,
  output logic [1:0]                     stretchCycles,
  output logic [15:0]                    ramResetBase
);

  logic [4:0]  eepromBaseBits;
  logic        eepromMapEnable;
  logic [1:0]  stretchSel;
  logic        romHighHalfOnly;
  logic        romMapEnable;
  logic        lockStretch;
  logic        lockHighHalf;
  logic        lockRomEnable;
  logic        lockEeBase;
  logic        romStrapTaken;
  logic        specialMode;
  logic        stretchMode;
  logic [15:0] eeSize;
  logic [15:0] relAddr;
  logic        hitEe;
  logic        hitMisc;
  logic [7:0]  next_regRdata;
  logic [4:0]  readSel;
  logic        eeBaseWritable;
  logic        stretchWritable;
  logic        highHalfWritable;
  logic        romWritable;
  logic        eeHitNow;
  logic        romHitNow;
  logic [1:0]  stretchNow;
  logic [15:0] ramBaseNow;

  function automatic logic isHit(input logic [15:0] rel, input logic [10:0] ofs);
    isHit = (rel == {5'h00, ofs});
  endfunction : isHit

  // write-once locks are lifted only in the three special modes
  function automatic logic modeIsSpecial(input mmc_ctrl_pkg::op_mode_t mode);
    unique case (mode)
      mmc_ctrl_pkg::MODE_NORMAL_EXP:  modeIsSpecial = 1'b0;
      mmc_ctrl_pkg::MODE_EMULATION:   modeIsSpecial = 1'b0;
      mmc_ctrl_pkg::MODE_PERIPHERAL:  modeIsSpecial = 1'b0;
      mmc_ctrl_pkg::MODE_SINGLE_CHIP: modeIsSpecial = 1'b0;
      mmc_ctrl_pkg::MODE_SPECIAL_SC:  modeIsSpecial = 1'b1;
      mmc_ctrl_pkg::MODE_SPECIAL_TST: modeIsSpecial = 1'b1;
      mmc_ctrl_pkg::MODE_SPECIAL_EXP: modeIsSpecial = 1'b1;
      // the spare code keeps the locks, the safer of the two readings
      default:                        modeIsSpecial = 1'b0;
    endcase
  endfunction : modeIsSpecial

  // only modes with an external bus stretch; the others ignore the field
  function automatic logic modeHasExternalBus(input mmc_ctrl_pkg::op_mode_t mode);
    unique case (mode)
      mmc_ctrl_pkg::MODE_NORMAL_EXP:  modeHasExternalBus = 1'b1;
      mmc_ctrl_pkg::MODE_EMULATION:   modeHasExternalBus = 1'b1;
      mmc_ctrl_pkg::MODE_PERIPHERAL:  modeHasExternalBus = 1'b0;
      mmc_ctrl_pkg::MODE_SINGLE_CHIP: modeHasExternalBus = 1'b0;
      mmc_ctrl_pkg::MODE_SPECIAL_SC:  modeHasExternalBus = 1'b0;
      mmc_ctrl_pkg::MODE_SPECIAL_TST: modeHasExternalBus = 1'b1;
      mmc_ctrl_pkg::MODE_SPECIAL_EXP: modeHasExternalBus = 1'b1;
      // no stretch on the spare code, so a bad mode never slows the bus
      default:                        modeHasExternalBus = 1'b0;
    endcase
  endfunction : modeHasExternalBus

  // one lock rule shared by every write-once field
  function automatic logic writeAllowed(input logic special, input logic locked);
    writeAllowed = special || !locked;
  endfunction : writeAllowed

  function automatic logic [15:0] eeSizeOf(input logic [1:0] code);
    unique case (code)
      2'h0: eeSizeOf = 16'h0000;
      2'h1: eeSizeOf = 16'h0800;
      2'h2: eeSizeOf = 16'h1000;
      2'h3: eeSizeOf = 16'h2000;
    endcase
  endfunction : eeSizeOf

  // reset base of the ram array, from the size code alone
  function automatic logic [15:0] ramBaseOf(input logic [2:0] code);
    unique case (code)
      3'h0: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE0;
      3'h1: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE1;
      3'h2: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE2;
      3'h3: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE3;
      3'h4: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE4;
      3'h5: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE5;
      3'h6: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE6;
      3'h7: ramBaseOf = mmc_ctrl_pkg::RAM_BASE_CODE7;
    endcase
  endfunction : ramBaseOf

  // the window end is one bit wider so a window at the top of the map does not wrap
  function automatic logic eeInside(input logic [15:0] addr, input logic [4:0] baseBits,
                                    input logic [15:0] size);
    logic [16:0] windowEnd;
    windowEnd = {1'b0, baseBits, 11'h000} + {1'b0, size};
    eeInside  = (size != 16'h0000) && (addr >= {baseBits, 11'h000}) &&
                ({1'b0, addr} < windowEnd);
  endfunction : eeInside

  // upper half always holds rom; the fixed lower pages only while not blocked
  function automatic logic romInside(input logic [15:0] addr, input logic highHalfOnly);
    logic upperHalf;
    logic lowerPages;
    upperHalf  = addr[15];
    lowerPages = (addr[15:14] == 2'h1);
    romInside  = upperHalf || (!highHalfOnly && lowerPages);
  endfunction : romInside

  function automatic logic [7:0] eePositionView(input logic [4:0] baseBits,
                                                input logic       enable);
    eePositionView = {baseBits, 2'h0, enable};
  endfunction : eePositionView

  // bits 7 to 4 do not exist and read as zero
  function automatic logic [7:0] miscView(input logic [1:0] stretch, input logic highHalf,
                                          input logic       rom_map_enable);
    miscView = {4'h0, stretch, highHalf, rom_map_enable};
  endfunction : miscView

  function automatic logic [7:0] sizeView(input logic regSpace, input logic [1:0] eeCode,
                                          input logic [2:0] ramCode);
    sizeView = {regSpace, 1'b0, eeCode, 1'b0, ramCode};
  endfunction : sizeView

  assign specialMode = modeIsSpecial(opMode);
  assign stretchMode = modeHasExternalBus(opMode);

  assign relAddr = regAddr - registerBlockBase;
  assign hitEe   = regWrite && isHit(relAddr, mmc_ctrl_pkg::OFS_EEPROM_POSITION);
  assign hitMisc = regWrite && isHit(relAddr, mmc_ctrl_pkg::OFS_MISC_CONTROL);

  // one-hot read select; an unmapped offset leaves it all zero
  assign readSel[0] = regRead && isHit(relAddr, mmc_ctrl_pkg::OFS_EEPROM_POSITION);
  assign readSel[1] = regRead && isHit(relAddr, mmc_ctrl_pkg::OFS_MISC_CONTROL);
  assign readSel[2] = regRead && isHit(relAddr, mmc_ctrl_pkg::OFS_TEST_A);
  assign readSel[3] = regRead && isHit(relAddr, mmc_ctrl_pkg::OFS_TEST_B);
  assign readSel[4] = regRead && isHit(relAddr, mmc_ctrl_pkg::OFS_SIZE_VIEW_A);

  assign eeSize = eeSizeOf(eepromSizeSwitch);

  // eeprom enable may be rewritten at any time, in any mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      eepromMapEnable <= mmc_ctrl_pkg::EE_POSITION_RESET[0];
    end else if (hitEe) begin
      eepromMapEnable <= regWdata[mmc_ctrl_pkg::EE_ENABLE];
    end
  end

  // base bits honour the lock only when the integration asks for write-once
  assign eeBaseWritable = !EE_BASE_WRITE_ONCE || writeAllowed(specialMode, lockEeBase);

  always_ff @(posedge mclk) begin
    if (srst) begin
      eepromBaseBits <= mmc_ctrl_pkg::EE_POSITION_RESET[7:3];
    end else if (hitEe && eeBaseWritable) begin
      eepromBaseBits <= regWdata[mmc_ctrl_pkg::EE_BASE_MSB:mmc_ctrl_pkg::EE_BASE_LSB];
    end
  end

  // any write locks, even one that the lock itself refused
  always_ff @(posedge mclk) begin
    if (srst) begin
      lockEeBase <= 1'b0;
    end else if (hitEe) begin
      lockEeBase <= 1'b1;
    end
  end

  // misc control; each field carries its own lock
  assign stretchWritable  = writeAllowed(specialMode, lockStretch);
  assign highHalfWritable = writeAllowed(specialMode, lockHighHalf);
  assign romWritable      = writeAllowed(specialMode, lockRomEnable);

  always_ff @(posedge mclk) begin
    if (srst) begin
      stretchSel <= mmc_ctrl_pkg::STRETCH_RESET;
    end else if (hitMisc && stretchWritable) begin
      stretchSel <= regWdata[mmc_ctrl_pkg::MISC_STRETCH_MSB:mmc_ctrl_pkg::MISC_STRETCH_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      romHighHalfOnly <= mmc_ctrl_pkg::HIGH_HALF_RESET;
    end else if (hitMisc && highHalfWritable) begin
      romHighHalfOnly <= regWdata[mmc_ctrl_pkg::MISC_HIGH_HALF];
    end
  end

  // a write to misc locks all three fields, even those it was refused
  always_ff @(posedge mclk) begin
    if (srst) begin
      lockStretch <= 1'b0;
    end else if (hitMisc) begin
      lockStretch <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lockHighHalf <= 1'b0;
    end else if (hitMisc) begin
      lockHighHalf <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lockRomEnable <= 1'b0;
    end else if (hitMisc) begin
      lockRomEnable <= 1'b1;
    end
  end

  // the strap is taken in the first cycle after reset release, never under reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      romStrapTaken <= 1'b0;
    end else begin
      romStrapTaken <= 1'b1;
    end
  end

  // a misc write in that first cycle loses to the strap
  always_ff @(posedge mclk) begin
    if (srst) begin
      romMapEnable <= 1'b0;
    end else if (!romStrapTaken) begin
      romMapEnable <= romResetEnable;
    end else if (hitMisc && romWritable) begin
      romMapEnable <= regWdata[mmc_ctrl_pkg::MISC_ROM_ENABLE];
    end
  end

  // next decode values; the outputs register them, so a write shows two edges on
  assign eeHitNow   = eepromMapEnable && eeInside(cpuAddr, eepromBaseBits, eeSize);
  assign romHitNow  = romMapEnable && romInside(cpuAddr, romHighHalfOnly);
  assign stretchNow = stretchMode ? stretchSel : 2'h0;
  assign ramBaseNow = ramBaseOf(ramSizeSwitch);

  // state written at one edge drives the decode from the next edge on
  always_ff @(posedge mclk) begin
    if (srst) begin
      eepromSelect <= 1'b0;
    end else begin
      eepromSelect <= eeHitNow;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      romSelect <= 1'b0;
    end else begin
      romSelect <= romHitNow;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stretchCycles <= 2'h0;
    end else begin
      stretchCycles <= stretchNow;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ramResetBase <= 16'h0000;
    end else begin
      ramResetBase <= ramBaseNow;
    end
  end

  // offsets are exact, so at most one select bit is ever high
  always_comb begin
    next_regRdata = 8'h00;
    unique case (1'b1)
      readSel[0]: next_regRdata = eePositionView(eepromBaseBits, eepromMapEnable);
      readSel[1]: next_regRdata = miscView(stretchSel, romHighHalfOnly, romMapEnable);
      readSel[2]: next_regRdata = TEST_A_VALUE;
      readSel[3]: next_regRdata = TEST_B_VALUE;
      readSel[4]: next_regRdata = sizeView(registerSpaceSwitch, eepromSizeSwitch, ramSizeSwitch);
      default:    next_regRdata = 8'h00;
    endcase
  end

  // unmapped reads return zero; data valid only the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule : memory_map_control_regs

`default_nettype wire
